// [src/supply_monitor_regs.sv]
// Purpose: Diagnostic pull-up, power control and supply monitor flag registers
// Assumes: Processor bus single-cycle byte strobes; paged port on page two
// Notes:   Both ports share the bank; processor wins on a same-cycle write
`timescale 1ns/1ps
`default_nettype none
module supply_monitor_regs (
	input  wire logic                               sys_clk,
	input  wire logic                               rstn,
	input  wire logic                               cpu_sel,
	input  wire logic                               cpu_write,
	input  wire logic [31:0]                        cpu_addr,
	input  wire logic [7:0]                         cpu_wdata,
	output var  logic [7:0]                         cpu_rdata,
	output var  logic                               cpu_hit,
	input  wire logic                               page_sel,
	input  wire logic                               page_write,
	input  wire logic [1:0]                         page_addr,
	input  wire logic [7:0]                         page_offset,
	input  wire logic [7:0]                         page_wdata,
	output var  logic [7:0]                         page_rdata,
	output var  logic                               page_hit,
	input  wire supply_monitor_pkg::monitor_events_t monitor_async,
	output var  supply_monitor_pkg::analog_controls_t controls
);
	supply_monitor_pkg::monitor_events_t  mon;
	supply_monitor_pkg::analog_controls_t next_controls;
	logic [7:0] diag_pullup_config;
	logic [7:0] analog_power_control;
	logic [7:0] digital_power_control;
	logic [7:0] supply_monitor_flags_one;
	logic [7:0] supply_monitor_flags_two;
	logic [7:0] next_diag;
	logic [7:0] next_analog;
	logic [7:0] next_digital;
	logic [7:0] next_flags_one;
	logic [7:0] next_flags_two;
	logic [7:0] next_cpu_rdata;
	logic [7:0] next_page_rdata;
	logic       next_cpu_hit;
	logic       next_page_hit;
	logic [7:0] wr_sel;
	logic [7:0] set_one;
	logic [7:0] set_two;
	logic       cpu_wr;
	logic       page_wr;

	level_sync3 #(
		.WIDTH ($bits(supply_monitor_pkg::monitor_events_t))
	) u_sync (
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.async_in (monitor_async),
		.sync_out (mon)
	);

	// Index of the register at a byte offset; 5 means unmapped
	function automatic logic [2:0] reg_index(input logic [7:0] ofs);
		case (ofs)
			supply_monitor_pkg::ADDR_DIAG_PULLUP_CONFIG[7:0]: reg_index = 3'h0;
			supply_monitor_pkg::ADDR_ANALOG_POWER[7:0]:       reg_index = 3'h1;
			supply_monitor_pkg::ADDR_DIGITAL_POWER[7:0]:      reg_index = 3'h2;
			supply_monitor_pkg::ADDR_SUPPLY_FLAGS_ONE[7:0]:   reg_index = 3'h3;
			supply_monitor_pkg::ADDR_SUPPLY_FLAGS_TWO[7:0]:   reg_index = 3'h4;
			default:                                          reg_index = 3'h5;
		endcase
	endfunction

	function automatic logic cpu_in_page(input logic [31:0] addr);
		cpu_in_page = (addr[31:8] == supply_monitor_pkg::ADDR_ANALOG_POWER[31:8]);
	endfunction

	function automatic logic [7:0] read_reg(
		input logic [2:0] idx,
		input logic [7:0] r0,
		input logic [7:0] r1,
		input logic [7:0] r2,
		input logic [7:0] r3,
		input logic [7:0] r4
	);
		case (idx)
			3'h0:    read_reg = r0;
			3'h1:    read_reg = r1;
			3'h2:    read_reg = r2;
			3'h3:    read_reg = r3;
			3'h4:    read_reg = r4;
			default: read_reg = 8'h00;
		endcase
	endfunction

	logic [2:0] cpu_idx;
	logic [2:0] page_idx;
	logic       cpu_ok;
	logic       page_ok;

	always_comb begin
		cpu_idx  = reg_index(cpu_addr[7:0]);
		page_idx = reg_index(page_offset);
		cpu_ok   = cpu_sel && cpu_in_page(cpu_addr) && (cpu_idx != 3'h5);
		page_ok  = page_sel && (page_addr == supply_monitor_pkg::PAGE_REGS) && (page_idx != 3'h5);
		cpu_wr   = cpu_ok && cpu_write;
		page_wr  = page_ok && page_write && !(cpu_wr && (cpu_idx == page_idx));
	end

	// Per-register write strobe; a byte write to one register at a time per port
	always_comb begin
		wr_sel  = 8'h00;
		for (int i = 0; i < 5; i++) begin
			if (cpu_wr && (cpu_idx == 3'(i))) begin
				wr_sel[i] = 1'b1;
			end
			if (page_wr && (page_idx == 3'(i))) begin
				wr_sel[i] = 1'b1;
			end
		end
	end

	function automatic logic [7:0] port_data(
		input logic [2:0] idx,
		input logic       cw,
		input logic [2:0] ci,
		input logic [7:0] cd,
		input logic [7:0] pd
	);
		port_data = (cw && (ci == idx)) ? cd : pd;
	endfunction

	always_comb begin
		set_one = 8'h00;
		set_one[supply_monitor_pkg::BIT_VBIAS_OVER]          = mon.vbias_over;
		set_one[supply_monitor_pkg::BIT_VBIAS_UNDER]         = mon.vbias_under;
		set_one[supply_monitor_pkg::BIT_ANALOG_SUPPLY_OVER]  = mon.analog_supply_over;
		set_one[supply_monitor_pkg::BIT_ANALOG_SUPPLY_UNDER] = mon.analog_supply_under;
		set_one[supply_monitor_pkg::BIT_DRIVE_SUPPLY_OVER]   = mon.drive_supply_over;
		set_one[supply_monitor_pkg::BIT_DRIVE_SUPPLY_UNDER]  = mon.drive_supply_under;
		set_two = 8'h00;
		set_two[supply_monitor_pkg::BIT_CORE_SUPPLY_OVER] = mon.core_supply_over;
		set_two[supply_monitor_pkg::BIT_CLOCK_FAULT]      = mon.clock_fault;
	end

	always_comb begin
		logic [7:0] d;
		d              = 8'h00;
		next_diag      = diag_pullup_config;
		next_analog    = analog_power_control;
		next_digital   = digital_power_control;
		next_flags_one = supply_monitor_flags_one;
		next_flags_two = supply_monitor_flags_two;
		if (wr_sel[0]) begin
			d         = port_data(3'h0, cpu_wr, cpu_idx, cpu_wdata, page_wdata);
			next_diag = d & supply_monitor_pkg::MASK_DIAG_PULLUP_CONFIG;
		end
		if (wr_sel[1]) begin
			d           = port_data(3'h1, cpu_wr, cpu_idx, cpu_wdata, page_wdata);
			next_analog = d & supply_monitor_pkg::MASK_ANALOG_POWER;
		end
		if (wr_sel[2]) begin
			d            = port_data(3'h2, cpu_wr, cpu_idx, cpu_wdata, page_wdata);
			next_digital = d & supply_monitor_pkg::MASK_DIGITAL_POWER;
		end
		if (wr_sel[3]) begin
			d              = port_data(3'h3, cpu_wr, cpu_idx, cpu_wdata, page_wdata);
			next_flags_one = next_flags_one & ~(d & supply_monitor_pkg::MASK_FLAGS_ONE);
		end
		if (wr_sel[4]) begin
			d              = port_data(3'h4, cpu_wr, cpu_idx, cpu_wdata, page_wdata);
			// Clock-ok bit is not cleared here; it follows the live check
			next_flags_two = next_flags_two & ~(d & supply_monitor_pkg::MASK_FLAGS_TWO_CLEAR);
			next_flags_two[supply_monitor_pkg::BIT_CLOCK_CHECK_ENABLE] =
				d[supply_monitor_pkg::BIT_CLOCK_CHECK_ENABLE];
		end
		// Sets applied last so an event in the clearing cycle survives
		next_flags_one = (next_flags_one | set_one) & supply_monitor_pkg::MASK_FLAGS_ONE;
		next_flags_two = next_flags_two | set_two;
		// Clock-ok reads live and only while the check runs
		next_flags_two[supply_monitor_pkg::BIT_CLOCK_OK] = mon.clock_ok &&
			next_flags_two[supply_monitor_pkg::BIT_CLOCK_CHECK_ENABLE];
		next_flags_two[7] = 1'b0;
		next_flags_two[3:1] = 3'h0;
	end

	always_comb begin
		next_controls.secondary_a_pullup_on =
			next_diag[supply_monitor_pkg::BIT_SECONDARY_A_PULLUP_ON];
		next_controls.secondary_b_pullup_on =
			next_diag[supply_monitor_pkg::BIT_SECONDARY_B_PULLUP_ON];
		next_controls.primary_ext_pullup_on =
			next_diag[supply_monitor_pkg::BIT_PRIMARY_EXT_PULLUP_ON];
		next_controls.aux_input_pullup_on =
			!next_diag[supply_monitor_pkg::BIT_AUX_INPUT_PULLUP_OFF];
		next_controls.frontend_shutdown =
			next_analog[supply_monitor_pkg::BIT_FRONTEND_SHUTDOWN];
		next_controls.vref_enable =
			next_analog[supply_monitor_pkg::BIT_VREF_ENABLE];
		next_controls.gate_drive_enable =
			!next_analog[supply_monitor_pkg::BIT_GATE_DRIVE_DISABLE];
		next_controls.one_wire_clock_gate =
			next_digital[supply_monitor_pkg::BIT_ONE_WIRE_CLOCK_GATE];
		next_controls.clock_check_enable =
			next_flags_two[supply_monitor_pkg::BIT_CLOCK_CHECK_ENABLE];
	end

	// Reads return the value before any same-cycle write
	always_comb begin
		next_cpu_hit    = cpu_ok;
		next_page_hit   = page_ok;
		next_cpu_rdata  = cpu_ok ? read_reg(cpu_idx, diag_pullup_config, analog_power_control,
			digital_power_control, supply_monitor_flags_one, supply_monitor_flags_two) : 8'h00;
		next_page_rdata = page_ok ? read_reg(page_idx, diag_pullup_config, analog_power_control,
			digital_power_control, supply_monitor_flags_one, supply_monitor_flags_two) : 8'h00;
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			diag_pullup_config       <= supply_monitor_pkg::RST_DIAG_PULLUP_CONFIG;
			analog_power_control     <= supply_monitor_pkg::RST_ANALOG_POWER;
			digital_power_control    <= supply_monitor_pkg::RST_DIGITAL_POWER;
			supply_monitor_flags_one <= supply_monitor_pkg::RST_SUPPLY_FLAGS_ONE;
			supply_monitor_flags_two <= supply_monitor_pkg::RST_SUPPLY_FLAGS_TWO;
			controls                 <= '{secondary_a_pullup_on: 1'b0, secondary_b_pullup_on: 1'b0,
				aux_input_pullup_on: 1'b1, primary_ext_pullup_on: 1'b0, frontend_shutdown: 1'b1,
				vref_enable: 1'b0, gate_drive_enable: 1'b1, one_wire_clock_gate: 1'b0,
				clock_check_enable: 1'b0};
			cpu_rdata                <= 8'h00;
			cpu_hit                  <= 1'b0;
			page_rdata               <= 8'h00;
			page_hit                 <= 1'b0;
		end else begin
			diag_pullup_config       <= next_diag;
			analog_power_control     <= next_analog;
			digital_power_control    <= next_digital;
			supply_monitor_flags_one <= next_flags_one;
			supply_monitor_flags_two <= next_flags_two;
			controls                 <= next_controls;
			cpu_rdata                <= next_cpu_rdata;
			cpu_hit                  <= next_cpu_hit;
			page_rdata               <= next_page_rdata;
			page_hit                 <= next_page_hit;
		end
	end
endmodule
`default_nettype wire

// [common/supply_monitor_pkg.sv]
// Purpose: Constants and carrier types for the supply monitor register bank
// Assumes: Byte-wide registers, byte addresses on a 32-bit processor bus
// Notes:   Page offsets are the low byte of the processor address
package supply_monitor_pkg;
	localparam logic [31:0] ADDR_DIAG_PULLUP_CONFIG = 32'h40000545;
	localparam logic [31:0] ADDR_ANALOG_POWER       = 32'h40000550;
	localparam logic [31:0] ADDR_DIGITAL_POWER      = 32'h40000554;
	localparam logic [31:0] ADDR_SUPPLY_FLAGS_ONE   = 32'h40000558;
	localparam logic [31:0] ADDR_SUPPLY_FLAGS_TWO   = 32'h40000559;
	localparam logic [1:0]  PAGE_REGS               = 2'h2;

	localparam logic [7:0] RST_DIAG_PULLUP_CONFIG = 8'h00;
	localparam logic [7:0] RST_ANALOG_POWER       = 8'h01;
	localparam logic [7:0] RST_DIGITAL_POWER      = 8'h00;
	localparam logic [7:0] RST_SUPPLY_FLAGS_ONE   = 8'h00;
	localparam logic [7:0] RST_SUPPLY_FLAGS_TWO   = 8'h00;

	// Field positions
	localparam int BIT_SECONDARY_A_PULLUP_ON = 0;
	localparam int BIT_SECONDARY_B_PULLUP_ON = 1;
	localparam int BIT_AUX_INPUT_PULLUP_OFF  = 2;
	localparam int BIT_PRIMARY_EXT_PULLUP_ON = 3;
	localparam int BIT_FRONTEND_SHUTDOWN     = 0;
	localparam int BIT_VREF_ENABLE           = 2;
	localparam int BIT_GATE_DRIVE_DISABLE    = 4;
	localparam int BIT_ONE_WIRE_CLOCK_GATE   = 0;
	localparam int BIT_VBIAS_OVER            = 2;
	localparam int BIT_VBIAS_UNDER           = 3;
	localparam int BIT_ANALOG_SUPPLY_OVER    = 4;
	localparam int BIT_ANALOG_SUPPLY_UNDER   = 5;
	localparam int BIT_DRIVE_SUPPLY_OVER     = 6;
	localparam int BIT_DRIVE_SUPPLY_UNDER    = 7;
	localparam int BIT_CORE_SUPPLY_OVER      = 0;
	localparam int BIT_CLOCK_FAULT           = 4;
	localparam int BIT_CLOCK_OK              = 5;
	localparam int BIT_CLOCK_CHECK_ENABLE    = 6;

	// Writable masks; other bits read zero except clock-ok and check-enable in flags two
	localparam logic [7:0] MASK_DIAG_PULLUP_CONFIG = 8'h0F;
	localparam logic [7:0] MASK_ANALOG_POWER       = 8'h1F;
	localparam logic [7:0] MASK_DIGITAL_POWER      = 8'h01;
	localparam logic [7:0] MASK_FLAGS_ONE          = 8'hFC;
	localparam logic [7:0] MASK_FLAGS_TWO_CLEAR    = 8'h11;

	typedef struct packed {
		logic vbias_over;
		logic vbias_under;
		logic analog_supply_over;
		logic analog_supply_under;
		logic drive_supply_over;
		logic drive_supply_under;
		logic core_supply_over;
		logic clock_fault;
		logic clock_ok;
	} monitor_events_t;

	typedef struct packed {
		logic secondary_a_pullup_on;
		logic secondary_b_pullup_on;
		logic aux_input_pullup_on;
		logic primary_ext_pullup_on;
		logic frontend_shutdown;
		logic vref_enable;
		logic gate_drive_enable;
		logic one_wire_clock_gate;
		logic clock_check_enable;
	} analog_controls_t;
endpackage

// [src/level_sync3.sv]
// Purpose: Three-stage synchroniser for asynchronous monitor levels
// Assumes: Inputs come from analog comparators outside the clock domain
// Notes:   A change counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module level_sync3 #(
	parameter int WIDTH = 1
) (
	input  wire logic             sys_clk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_out;

	always_comb begin
		next_out = sync_out;
		for (int i = 0; i < WIDTH; i++) begin
			if (stage2[i] == stage3[i]) begin
				next_out[i] = stage3[i];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			stage1   <= '0;
			stage2   <= '0;
			stage3   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			stage2   <= stage1;
			stage3   <= stage2;
			sync_out <= next_out;
		end
	end
endmodule
`default_nettype wire

// [bench/supply_monitor_regs_checker.sv]
// Purpose: Port-level checks for the supply monitor register bank
// Assumes: One clock, asynchronous active-low reset
// Notes:   Sees only the top ports; attached by bind from the bench
`timescale 1ns/1ps
`default_nettype none
module supply_monitor_regs_checker (
	input wire logic                                 sys_clk,
	input wire logic                                 rstn,
	input wire logic                                 cpu_sel,
	input wire logic                                 cpu_write,
	input wire logic [31:0]                          cpu_addr,
	input wire logic [7:0]                           cpu_wdata,
	input wire logic [7:0]                           cpu_rdata,
	input wire logic                                 cpu_hit,
	input wire logic                                 page_sel,
	input wire logic [1:0]                           page_addr,
	input wire logic [7:0]                           page_rdata,
	input wire logic                                 page_hit,
	input wire supply_monitor_pkg::analog_controls_t controls
);
	logic cpu_map;
	logic cpu_wr;
	assign cpu_map = cpu_addr inside {supply_monitor_pkg::ADDR_DIAG_PULLUP_CONFIG,
		supply_monitor_pkg::ADDR_ANALOG_POWER, supply_monitor_pkg::ADDR_DIGITAL_POWER,
		supply_monitor_pkg::ADDR_SUPPLY_FLAGS_ONE, supply_monitor_pkg::ADDR_SUPPLY_FLAGS_TWO};
	assign cpu_wr = cpu_sel && cpu_write;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	AST_CPU_HIT: assert property (cpu_sel && cpu_map |=> cpu_hit)
		else $error("mapped access without hit");
	AST_CPU_REFUSE: assert property (!(cpu_sel && cpu_map) |=> !cpu_hit && cpu_rdata == 8'h00)
		else $error("unmapped processor access answered");
	AST_PAGE_REFUSE: assert property (page_sel && page_addr != 2'h2 |=> !page_hit && page_rdata == 8'h00)
		else $error("wrong page answered");
	AST_DIAG: assert property (cpu_wr && cpu_addr == supply_monitor_pkg::ADDR_DIAG_PULLUP_CONFIG |=>
		{controls.secondary_a_pullup_on, controls.secondary_b_pullup_on, controls.primary_ext_pullup_on}
		== {$past(cpu_wdata[0]), $past(cpu_wdata[1]), $past(cpu_wdata[3])})
		else $error("pull-up enables do not follow write");
	AST_AUX: assert property (cpu_wr && cpu_addr == supply_monitor_pkg::ADDR_DIAG_PULLUP_CONFIG |=>
		controls.aux_input_pullup_on != $past(cpu_wdata[2])) else $error("aux pull-up polarity wrong");
	AST_ANALOG: assert property (cpu_wr && cpu_addr == supply_monitor_pkg::ADDR_ANALOG_POWER |=>
		{controls.frontend_shutdown, controls.vref_enable, controls.gate_drive_enable}
		== {$past(cpu_wdata[0]), $past(cpu_wdata[2]), !$past(cpu_wdata[4])})
		else $error("analog power controls wrong");
	AST_ONE_WIRE: assert property (cpu_wr && cpu_addr == supply_monitor_pkg::ADDR_DIGITAL_POWER |=>
		controls.one_wire_clock_gate == $past(cpu_wdata[0])) else $error("one-wire clock gate wrong");
	AST_CHECK_EN: assert property (cpu_wr && cpu_addr == supply_monitor_pkg::ADDR_SUPPLY_FLAGS_TWO |=>
		controls.clock_check_enable == $past(cpu_wdata[6])) else $error("clock check enable wrong");
endmodule
`default_nettype wire

// [bench/supply_monitor_regs_test.sv]
// Purpose: Self-checking bench for the supply monitor register bank
// Assumes: Answers registered on the taking edge; flags settle within six cycles
// Notes:   Random writes from a fixed seed, readback through the other port
`timescale 1ns/1ps
`default_nettype none
module supply_monitor_regs_test;
	logic                                 sys_clk = 1'b0;
	logic                                 rstn = 1'b0;
	logic                                 cpu_sel = 1'b0, cpu_write = 1'b0;
	logic [31:0]                          cpu_addr = 32'h0;
	logic [7:0]                           cpu_wdata = 8'h00, page_wdata = 8'h00;
	logic [7:0]                           cpu_rdata, page_rdata, page_offset = 8'h00;
	logic                                 cpu_hit, page_hit;
	logic                                 page_sel = 1'b0, page_write = 1'b0;
	logic [1:0]                           page_addr = 2'h0;
	supply_monitor_pkg::monitor_events_t  mon = '0;
	supply_monitor_pkg::analog_controls_t controls;
	int                                   num_errors = 0, check_count = 0;
	integer                               seed = 82;
	logic [7:0]                           offs [5] = '{8'h45, 8'h50, 8'h54, 8'h58, 8'h59};
	logic [7:0]                           diag = 8'h00, ana = 8'h01, dig = 8'h00;
	logic                                 ck_en = 1'b0;
	supply_monitor_regs supply_monitor_regs_inst (.sys_clk, .rstn, .cpu_sel, .cpu_write,
		.cpu_addr, .cpu_wdata, .cpu_rdata, .cpu_hit, .page_sel, .page_write, .page_addr,
		.page_offset, .page_wdata, .page_rdata, .page_hit, .monitor_async(mon), .controls);
	initial forever #2.5 sys_clk = ~sys_clk;
	function automatic supply_monitor_pkg::analog_controls_t exp_ctrl();
		return '{diag[0], diag[1], !diag[2], diag[3], ana[0], ana[2], !ana[4], dig[0], ck_en};
	endfunction
	function automatic logic [7:0] exp_read(int i);
		// Flags stay clear while every monitor input is low
		case (i)
			0: return diag;
			1: return ana;
			2: return dig;
			4: return {1'b0, ck_en, 6'h00};
			default: return 8'h00;
		endcase
	endfunction
	task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected at %0t: byte %h, want %h", $time, g, e);
		end
	endtask
	task automatic check_ctrl(input supply_monitor_pkg::analog_controls_t e);
		check_count++;
		if (controls !== e) begin
			num_errors++;
			$display("unexpected at %0t: controls %b, want %b", $time, controls, e);
		end
	endtask
	task automatic xfer(input logic pg, input logic wr, input logic [31:0] a, input logic [7:0] wd,
		output logic [7:0] rd, output logic hit);
		@(negedge sys_clk);
		cpu_sel = !pg;
		page_sel = pg;
		cpu_write = wr;
		page_write = wr;
		cpu_addr = a;
		page_addr = (a[31:8] == 24'h400005) ? 2'h2 : 2'h1;
		page_offset = a[7:0];
		cpu_wdata = wd;
		page_wdata = wd;
		@(negedge sys_clk);
		cpu_sel = 1'b0;
		page_sel = 1'b0;
		rd = pg ? page_rdata : cpu_rdata;
		hit = pg ? page_hit : cpu_hit;
	endtask
	task automatic rd_chk(input logic pg, input logic [31:0] a, input logic [7:0] e);
		logic [7:0] r;
		logic       h;
		xfer(pg, 1'b0, a, 8'h00, r, h);
		check_byte({7'h00, h}, 8'h01);
		check_byte(r, e);
	endtask
	task automatic wr(input logic pg, input logic [31:0] a, input logic [7:0] d);
		logic [7:0] r;
		logic       h;
		xfer(pg, 1'b1, a, d, r, h);
	endtask
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		$display("unexpected at %0t: run too long", $time);
		end_of_test();
	end
	initial begin
		logic [31:0] a;
		logic [7:0]  d, b, k, r;
		logic        p, h;
		int          i;
		repeat (12) @(negedge sys_clk);
		rstn = 1'b1;
		check_ctrl(exp_ctrl());
		for (i = 0; i < 5; i++) rd_chk(i[0], {24'h400005, offs[i]}, exp_read(i));
		$display("test reset done");
		for (int n = 0; n < 50; n++) begin
			i = (n < 10) ? n % 5 : {$random(seed)} % 5;
			d = (n < 5) ? 8'hFF : (n < 10) ? 8'h00 : 8'($random(seed));
			p = 1'($random(seed));
			a = {24'h400005, offs[i]};
			wr(p, a, d);
			case (i)
				0: diag = d & 8'h0F;
				1: ana = d & 8'h1F;
				2: dig = d & 8'h01;
				4: ck_en = d[6];
				default: ;
			endcase
			rd_chk(!p, a, exp_read(i));
			check_ctrl(exp_ctrl());
		end
		$display("test random access done");
		for (i = 0; i < 2; i++) begin
			xfer(i[0], 1'b1, i[0] ? 32'h40000645 : 32'h40000546, 8'hFF, r, h);
			check_byte(r, 8'h00);
			check_byte({7'h00, h}, 8'h00);
			check_ctrl(exp_ctrl());
		end
		$display("test unmapped done");
		// Both ports write one register in one cycle; the processor data must win
		@(negedge sys_clk);
		{cpu_sel, page_sel, cpu_write, page_write} = 4'hF;
		cpu_addr = supply_monitor_pkg::ADDR_DIAG_PULLUP_CONFIG;
		page_addr = 2'h2;
		page_offset = 8'h45;
		cpu_wdata = 8'h05;
		page_wdata = 8'h0A;
		@(negedge sys_clk);
		{cpu_sel, page_sel} = 2'h0;
		check_byte({6'h00, cpu_hit, page_hit}, 8'h03);
		diag = 8'h05;
		rd_chk(1'b1, supply_monitor_pkg::ADDR_DIAG_PULLUP_CONFIG, 8'h05);
		check_ctrl(exp_ctrl());
		$display("test both ports done");
		wr(1'b0, supply_monitor_pkg::ADDR_SUPPLY_FLAGS_TWO, 8'h40);
		ck_en = 1'b1;
		for (i = 1; i < 9; i++) begin
			a = (i < 3) ? supply_monitor_pkg::ADDR_SUPPLY_FLAGS_TWO
				: supply_monitor_pkg::ADDR_SUPPLY_FLAGS_ONE;
			b = 8'h01 << ((i == 1) ? 4 : (i == 2) ? 0 : 10 - i);
			k = (i < 3) ? 8'h40 : 8'h00;
			mon[i] = 1'b1;
			repeat (6) @(negedge sys_clk);
			rd_chk(1'b0, a, b | k);
			wr(1'b0, a, b | k);
			rd_chk(1'b1, a, b | k);
			mon[i] = 1'b0;
			repeat (6) @(negedge sys_clk);
			rd_chk(1'b0, a, b | k);
			wr(1'b1, a, k);
			rd_chk(1'b1, a, b | k);
			wr(1'b1, a, b | k);
			rd_chk(1'b0, a, k);
		end
		$display("test fault flags done");
		mon.clock_ok = 1'b1;
		repeat (6) @(negedge sys_clk);
		rd_chk(1'b0, supply_monitor_pkg::ADDR_SUPPLY_FLAGS_TWO, 8'h60);
		wr(1'b1, supply_monitor_pkg::ADDR_SUPPLY_FLAGS_TWO, 8'h60);
		rd_chk(1'b0, supply_monitor_pkg::ADDR_SUPPLY_FLAGS_TWO, 8'h60);
		wr(1'b0, supply_monitor_pkg::ADDR_SUPPLY_FLAGS_TWO, 8'h20);
		rd_chk(1'b1, supply_monitor_pkg::ADDR_SUPPLY_FLAGS_TWO, 8'h00);
		ck_en = 1'b0;
		check_ctrl(exp_ctrl());
		$display("test clock check done");
		end_of_test();
	end
endmodule
bind supply_monitor_regs supply_monitor_regs_checker supply_monitor_regs_checker_inst (.sys_clk,
	.rstn, .cpu_sel, .cpu_write, .cpu_addr, .cpu_wdata, .cpu_rdata, .cpu_hit, .page_sel,
	.page_addr, .page_rdata, .page_hit, .controls);
`default_nettype wire
